// ---- hw/duty_rate_ticker.sv ----
`timescale 1ns/100ps
module duty_rate_ticker #(
    parameter int unsigned CYCLES_PER_SEC = fan_duty_ramp_pkg::CYCLES_PER_SEC
) (
    // clock and reset
    input  wire logic       i_sys_clk,
    input  wire logic       i_arst_n,
    // rate code
    input  wire logic [2:0] i_duty_update_rate,
    // update strobe
    output logic            o_tick
);

    localparam logic [31:0] BASE_PERIOD =
        32'(CYCLES_PER_SEC << fan_duty_ramp_pkg::RATE_BASE_SHIFT);

    logic [31:0] cnt_q;
    logic [31:0] cnt_d;
    logic [31:0] period;
    logic        tick_q;
    logic        tick_d;

    // period halves per code: 111 is 1/8 s, 100 is 1 s
    assign period = BASE_PERIOD >> i_duty_update_rate;

    // next count and strobe
    always_comb begin
        cnt_d  = cnt_q + 32'h0000_0001;
        tick_d = 1'b0;
        if (cnt_q >= period - 32'h0000_0001) begin
            cnt_d  = fan_duty_ramp_pkg::TICK_CNT_RESET;
            tick_d = 1'b1;
        end
    end

    // counter registers
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cnt_q  <= fan_duty_ramp_pkg::TICK_CNT_RESET;
            tick_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign o_tick = tick_q;

endmodule

// ---- hw/fan_duty_ramp_control.sv ----
`timescale 1ns/100ps
module fan_duty_ramp_control #(
    parameter int unsigned CYCLES_PER_SEC = fan_duty_ramp_pkg::CYCLES_PER_SEC
) (
    // clock and reset
    input  wire logic                           i_sys_clk,
    input  wire logic                           i_arst_n,
    // mode and configuration
    input  wire fan_duty_ramp_pkg::ctrl_mode_t  i_ctrl_mode,
    input  wire fan_duty_ramp_pkg::ramp_cfg_t   i_cfg,
    // duty sources
    input  wire logic [7:0]                     i_low_temp_duty,
    input  wire logic [7:0]                     i_remote_temp,
    input  wire logic [7:0]                     i_sw_duty,
    input  wire logic [7:0]                     i_rpm_target,
    input  wire logic                           i_rpm_tick,
    // applied duty and status
    output logic [7:0]                          o_duty_cycle_value,
    output logic [7:0]                          o_target_duty,
    output logic                                o_ramp_active,
    output logic                                o_update_tick
);

    typedef enum logic [1:0] {
        ST_HOLD = 2'b01,
        ST_RAMP = 2'b10
    } ramp_state_t;

    ramp_state_t state_q;
    ramp_state_t state_d;
    logic [7:0]  duty_q;
    logic [7:0]  duty_d;
    logic        rate_tick;
    logic        tick;
    logic [7:0]  auto_target;
    logic [7:0]  target;
    logic [7:0]  gap;
    logic [7:0]  step;
    logic [7:0]  thresh;
    logic        stepping;
    logic        is_auto;
    logic        is_rpm;
    logic        is_sw;

    // absolute difference of two duty values
    function automatic logic [7:0] abs_diff(input logic [7:0] a, input logic [7:0] b);
        abs_diff = (a >= b) ? (a - b) : (b - a);
    endfunction

    // step code to lsb per update
    function automatic logic [7:0] step_lsb(input logic [1:0] code);
        step_lsb = 8'h01 << code;
    endfunction

    // slope code to lsb per degree, smallest slope at 1 lsb
    function automatic logic [5:0] slope_lsb(input logic [2:0] code);
        if (code > fan_duty_ramp_pkg::SLOPE_CODE_MAX) begin
            slope_lsb = 6'h01;
        end else begin
            slope_lsb = fan_duty_ramp_pkg::SLOPE_BASE_LSB >> code;
        end
    endfunction

    // auto update strobe from the rate field
    duty_rate_ticker #(
        .CYCLES_PER_SEC (CYCLES_PER_SEC)
    ) u_ticker (
        .i_sys_clk          (i_sys_clk),
        .i_arst_n           (i_arst_n),
        .i_duty_update_rate (i_cfg.duty_update_rate),
        .o_tick             (rate_tick)
    );

    // remote temperature to target duty
    always_comb begin
        logic signed [8:0] excess;
        logic [13:0]       sum;
        excess = 9'sh000;
        sum    = 14'h0000;
        excess = $signed({i_remote_temp[7], i_remote_temp})
               - $signed({2'b00, i_cfg.remote_low_temp, 2'b00});
        if (excess <= 9'sh000) begin
            auto_target = i_low_temp_duty;
        end else begin
            sum = {6'h00, i_low_temp_duty}
                + 14'(excess[7:0] * slope_lsb(i_cfg.remote_slope));
            auto_target = (sum > 14'(fan_duty_ramp_pkg::DUTY_FULL)) ?
                          fan_duty_ramp_pkg::DUTY_FULL : sum[7:0];
        end
    end

    // mode decode and step parameters
    assign is_auto  = (i_ctrl_mode == fan_duty_ramp_pkg::MODE_AUTO_TEMP);
    assign is_rpm   = (i_ctrl_mode == fan_duty_ramp_pkg::MODE_SW_RPM);
    assign is_sw    = (i_ctrl_mode == fan_duty_ramp_pkg::MODE_SW_DUTY);
    assign target   = is_rpm ? i_rpm_target : (is_sw ? i_sw_duty : auto_target);
    assign gap      = abs_diff(target, duty_q);
    assign step     = step_lsb(i_cfg.duty_step_size);
    assign thresh   = {6'h00, i_cfg.adj_threshold};
    assign stepping = is_rpm || (is_auto && i_cfg.ramp_enable);
    assign tick     = is_rpm ? i_rpm_tick : rate_tick;

    // next duty
    always_comb begin
        duty_d  = duty_q;
        state_d = state_q;
        case (i_ctrl_mode)
            fan_duty_ramp_pkg::MODE_SW_DUTY: begin
                duty_d  = i_sw_duty;
                state_d = ST_HOLD;
            end
            fan_duty_ramp_pkg::MODE_SW_RPM,
            fan_duty_ramp_pkg::MODE_AUTO_TEMP: begin
                if (is_auto && gap <= thresh) begin
                    state_d = ST_HOLD;
                end else if (gap == 8'h00) begin
                    state_d = ST_HOLD;
                end else if (!stepping) begin
                    duty_d  = target;
                    state_d = ST_HOLD;
                end else begin
                    state_d = ST_RAMP;
                    if (tick) begin
                        if (gap <= step) begin
                            duty_d = target;
                        end else if (target > duty_q) begin
                            duty_d = duty_q + step;
                        end else begin
                            duty_d = duty_q - step;
                        end
                    end
                end
            end
            default: begin
                state_d = ST_HOLD;
            end
        endcase
    end

    // duty and state registers
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            duty_q  <= fan_duty_ramp_pkg::DUTY_RESET;
            state_q <= ST_HOLD;
        end else begin
            duty_q  <= duty_d;
            state_q <= state_d;
        end
    end

    // outputs
    assign o_duty_cycle_value = duty_q;
    assign o_target_duty      = target;
    assign o_ramp_active      = (state_q == ST_RAMP);
    assign o_update_tick      = tick;

    // checks
    sequence s_step_tick;
        stepping && tick && gap > 8'h00 && !(is_auto && gap <= thresh);
    endsequence

    sequence s_land;
        s_step_tick ##0 (gap <= step);
    endsequence

    AST_SW_DUTY: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        is_sw |=> duty_q == $past(i_sw_duty))
        else $error("software duty not applied");

    AST_IMMEDIATE: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        (is_auto && !i_cfg.ramp_enable && gap > thresh) |=> duty_q == $past(target))
        else $error("target not loaded at once");

    AST_NO_TICK_HOLD: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        (stepping && !tick) |=> $stable(duty_q))
        else $error("duty moved without an update tick");

    AST_STEP_CAP: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        (s_step_tick and is_auto) |=> abs_diff(duty_q, $past(duty_q)) <= $past(step))
        else $error("auto step exceeded step size");

    AST_RPM_EXACT: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        (s_step_tick and (is_rpm && gap > step))
        |=> abs_diff(duty_q, $past(duty_q)) == $past(step))
        else $error("rpm step not exact");

    AST_LAND: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        s_land |=> duty_q == $past(target))
        else $error("short gap not closed exactly");

    AST_NO_OVERSHOOT: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        (s_step_tick ##0 $stable(target))
        |=> abs_diff(duty_q, $past(target)) < $past(gap))
        else $error("step did not approach target");

    AST_THRESHOLD: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        (is_auto && gap <= thresh) |=> $stable(duty_q))
        else $error("adjustment within threshold applied");

    AST_SLOPE: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        (is_auto && $stable(i_cfg) && $stable(i_low_temp_duty)
         && $signed(i_remote_temp) > $signed({1'b0, i_cfg.remote_low_temp, 2'b00})
         && auto_target < fan_duty_ramp_pkg::DUTY_FULL)
        ##1 (i_remote_temp == $past(i_remote_temp) + 8'h01 && $stable(i_cfg)
             && $signed(i_remote_temp) > $signed($past(i_remote_temp))
             && $stable(i_low_temp_duty) && auto_target < fan_duty_ramp_pkg::DUTY_FULL)
        |-> auto_target - $past(auto_target) == 8'(slope_lsb(i_cfg.remote_slope)))
        else $error("slope per degree wrong");

endmodule

// ---- hw/fan_duty_ramp_pkg.sv ----
package fan_duty_ramp_pkg;

    // clock and update timing
    localparam int unsigned SYS_CLK_PERIOD_NS = 10;
    localparam int unsigned NS_PER_SEC        = 1000000000;
    localparam int unsigned UPDATE_BASE_SEC   = 1;
    localparam int unsigned CYCLES_PER_SEC    =
        (NS_PER_SEC / SYS_CLK_PERIOD_NS) * UPDATE_BASE_SEC;
    // base period spans 16 s so that every rate code is a right shift
    localparam int unsigned RATE_BASE_SHIFT   = 4;

    // reset values
    localparam logic [7:0]  DUTY_RESET        = 8'h00;
    localparam logic [31:0] TICK_CNT_RESET    = 32'h0000_0000;
    localparam logic        RAMP_ENABLE_RESET = 1'b0;

    // remote slope: 32 lsb per degree at code 000, halving per code down to 1 lsb at code 101, and 1 lsb at codes 110 and 111
    localparam logic [5:0]  SLOPE_BASE_LSB    = 6'h20;
    localparam logic [2:0]  SLOPE_CODE_MAX    = 3'h5;
    // low temperature field counts in steps of 4 degrees
    localparam int unsigned LOW_TEMP_SHIFT    = 2;
    localparam logic [7:0]  DUTY_FULL         = 8'hff;

    // control mode selection
    typedef enum logic [1:0] {
        MODE_AUTO_TEMP = 2'b00,
        MODE_SW_DUTY   = 2'b01,
        MODE_SW_RPM    = 2'b10
    } ctrl_mode_t;

    // configuration bits, packed in field order
    typedef struct packed {
        logic       ramp_enable;
        logic [1:0] duty_step_size;
        logic [2:0] duty_update_rate;
        logic [1:0] adj_threshold;
        logic [2:0] remote_slope;
        logic [4:0] remote_low_temp;
    } ramp_cfg_t;

endpackage

// ---- tb/fan_model.sv ----
`timescale 1ns/100ps
module fan_model #(
    parameter int unsigned SLOW_PERIOD = 5
) (
    // clock and reset
    input  wire logic       i_sys_clk,
    input  wire logic       i_arst_n,
    // duty drive from the controller, fast select from the bench
    input  wire logic [7:0] i_duty,
    input  wire logic       i_fast,
    // tach strobe and speed
    output logic            o_tach_tick,
    output logic [7:0]      o_speed
);
    int cnt_q;

    // tach strobe, back to back when fast
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cnt_q       <= 0;
            o_tach_tick <= 1'b0;
            o_speed     <= 8'h00;
        end else begin
            cnt_q       <= (cnt_q + 1) % SLOW_PERIOD;
            o_tach_tick <= i_fast || (cnt_q == 0);
            o_speed     <= i_duty; // rotor lags the drive
        end
    end
endmodule

// ---- tb/tb_top.sv ----
`timescale 1ns/100ps
module tb_top;
    localparam int unsigned CPS = 64;
    logic                          sys_clk = 1'b0;
    logic                          arst_n;
    fan_duty_ramp_pkg::ctrl_mode_t mode;
    fan_duty_ramp_pkg::ramp_cfg_t  cfg;
    logic [7:0]                    low_duty, remote_temp, sw_duty, rpm_target, duty, target;
    logic                          fast, fan_tick, upd_tick;
    logic                          ramp, exp_tick, exp_ramp;
    int                            tick_cnt, tick_per;
    logic [31:0]                   lfsr_q;
    logic [7:0]                    ref_n;
    int                            exp_duty, num_errors, checks_done, cycles;

    // clock
    always #5 sys_clk = ~sys_clk;

    fan_duty_ramp_control #(.CYCLES_PER_SEC(CPS)) dut_u (
        .i_sys_clk(sys_clk), .i_arst_n(arst_n), .i_ctrl_mode(mode), .i_cfg(cfg),
        .i_low_temp_duty(low_duty), .i_remote_temp(remote_temp), .i_sw_duty(sw_duty),
        .i_rpm_target(rpm_target), .i_rpm_tick(fan_tick), .o_duty_cycle_value(duty),
        .o_target_duty(target), .o_ramp_active(ramp), .o_update_tick(upd_tick));

    fan_model fan_u (
        .i_sys_clk(sys_clk), .i_arst_n(arst_n), .i_duty(duty), .i_fast(fast),
        .o_tach_tick(fan_tick), .o_speed());

    function automatic logic [7:0] rnd();
        lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
        return lfsr_q[7:0];
    endfunction

    // expected target from the mode and the temperature curve
    function automatic int tgt_f();
        int low, t, v;
        low = cfg.remote_low_temp * 4;
        t   = $signed(remote_temp);
        v   = t - low;
        v   = (cfg.remote_slope <= 3'h5) ? v * (32 >> cfg.remote_slope) : v;
        v   = low_duty + v;
        if (mode == fan_duty_ramp_pkg::MODE_SW_DUTY) return sw_duty;
        if (mode == fan_duty_ramp_pkg::MODE_SW_RPM) return rpm_target;
        if (t <= low) return low_duty;
        return (v > 255) ? 255 : v;
    endfunction

    // expected duty one edge later
    function automatic int next_f(int d);
        int t, g, s;
        t = tgt_f();
        g = (t > d) ? t - d : d - t;
        s = 1 << cfg.duty_step_size;
        s = (s > g) ? g : s;
        s = (t > d) ? s : -s;
        case (mode)
            fan_duty_ramp_pkg::MODE_SW_DUTY: return sw_duty;
            fan_duty_ramp_pkg::MODE_SW_RPM: return fan_tick ? d + s : d;
            fan_duty_ramp_pkg::MODE_AUTO_TEMP: begin
                if (g > cfg.adj_threshold) return cfg.ramp_enable ? (exp_tick ? d + s : d) : t;
            end
            default: return d;
        endcase
        return d;
    endfunction

    // expected stepping state one edge later
    function automatic logic ramp_f(int d);
        int t, g;
        t = tgt_f();
        g = (t > d) ? t - d : d - t;
        if (mode == fan_duty_ramp_pkg::MODE_SW_RPM) return g > 0;
        if (mode == fan_duty_ramp_pkg::MODE_AUTO_TEMP) return cfg.ramp_enable && g > cfg.adj_threshold;
        return 1'b0;
    endfunction

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic stop_test();
        $display("checks_done=%0d num_errors=%0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // reference model on the design's edges
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            exp_duty = 0;
            exp_ramp = 1'b0;
            exp_tick = 1'b0;
            tick_cnt = 0;
        end else begin
            exp_ramp = ramp_f(exp_duty);
            exp_duty = next_f(exp_duty);
            // own rate ticker: period halves per rate code
            tick_per = (CPS << fan_duty_ramp_pkg::RATE_BASE_SHIFT) >> cfg.duty_update_rate;
            exp_tick = (tick_cnt >= tick_per - 1);
            tick_cnt = exp_tick ? 0 : tick_cnt + 1;
        end
    end

    // compare every cycle where outputs are settled
    always @(negedge sys_clk) begin
        cmp(duty, exp_duty);
        if (mode != 2'b11) cmp(target, tgt_f());
        if (mode == fan_duty_ramp_pkg::MODE_SW_RPM) cmp(upd_tick, fan_tick);
        if (mode != fan_duty_ramp_pkg::MODE_SW_RPM) cmp(upd_tick, exp_tick);
        cmp(ramp, exp_ramp);
    end

    // hang guard
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            stop_test();
        end
    end

    // drive n cycles, refreshing random sources every hold cycles
    task automatic run(input fan_duty_ramp_pkg::ctrl_mode_t m, input logic ramp,
                       input logic [1:0] st, input logic [2:0] rate, input int hold, input int n);
        logic [7:0] r;
        int         i;
        for (i = 0; i < n; i++) begin
            @(posedge sys_clk);
            mode                 <= m;
            cfg.ramp_enable      <= ramp;
            cfg.duty_step_size   <= st;
            cfg.duty_update_rate <= rate;
            if (i % hold == 0) begin
                ref_n++;
                cfg.adj_threshold   <= ref_n[1:0];
                cfg.remote_slope    <= ref_n[4:2];
                r = rnd();
                sw_duty <= r;
                r = rnd();
                rpm_target <= r;
                r = rnd();
                low_duty <= r;
                r = rnd();
                remote_temp <= r;
                cfg.remote_low_temp <= lfsr_q[12:8];
                fast <= lfsr_q[13];
            end
        end
    endtask

    // auto curve swept one degree a cycle
    task automatic sweep(input logic [2:0] slope, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge sys_clk);
            mode                <= fan_duty_ramp_pkg::MODE_AUTO_TEMP;
            cfg.ramp_enable     <= 1'b0;
            cfg.remote_slope    <= slope;
            cfg.remote_low_temp <= 5'h00;
            low_duty            <= 8'h00;
            remote_temp         <= i[7:0];
        end
    endtask

    // spacing of update strobes after the rate settles
    task automatic period(input logic [2:0] rate, input int exp);
        int c;
        run(fan_duty_ramp_pkg::MODE_AUTO_TEMP, 1'b1, 2'h0, rate, 4096, 1);
        c = 0;
        repeat (2) begin
            @(negedge sys_clk);
            while (upd_tick !== 1'b1 && c < 3000) begin @(negedge sys_clk); c++; end
        end
        c = 0;
        @(negedge sys_clk);
        while (upd_tick !== 1'b1 && c < 3000) begin @(negedge sys_clk); c++; end
        cmp(c + 1, exp);
    endtask

    // main sequence
    initial begin
        arst_n      = 1'b0;
        mode        = fan_duty_ramp_pkg::MODE_SW_DUTY;
        cfg         = '0;
        {low_duty, remote_temp, sw_duty, rpm_target} = 32'h0000_0000;
        fast        = 1'b0;
        lfsr_q      = 32'h0000_0aa9;
        ref_n       = 8'h00;
        num_errors  = 0;
        checks_done = 0;
        cycles      = 0;
        repeat (4) @(posedge sys_clk);
        arst_n <= 1'b1;
        for (int k = 0; k < 4; k++) run(fan_duty_ramp_pkg::MODE_SW_DUTY, 1'b1, k[1:0], 3'h7, 4, 40);
        for (int k = 0; k < 4; k++) run(fan_duty_ramp_pkg::MODE_SW_RPM, k[0], k[1:0], 3'h0, 32, 300);
        run(fan_duty_ramp_pkg::MODE_AUTO_TEMP, 1'b0, 2'h3, 3'h7, 8, 400);
        for (int k = 0; k < 4; k++) run(fan_duty_ramp_pkg::MODE_AUTO_TEMP, 1'b1, k[1:0], 3'h7, 200, 400);
        run(fan_duty_ramp_pkg::ctrl_mode_t'(2'b11), 1'b1, 2'h1, 3'h7, 16, 64);
        period(3'h7, CPS / 8);
        period(3'h4, CPS);
        sweep(3'h5, 100);
        sweep(3'h0, 8);
        stop_test();
    end
endmodule
